/* File: logic/i2c_master.sv */
/*
  two-wire bus master engine: start, byte transmit with arbitration, byte
  receive, acknowledge and stop sequences, bus start/stop monitor.
  assumes open-drain pads outside: an enable high pulls the wire low, the
  wire levels come back on i_scl_i and i_sda_i from another clock domain.
*/
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - receive request ignored unless port idle
// - receive toggles clock each rollover, shifts data
// - eighth falling edge: store byte, flag, hold low
// - buffer-full set on store, cleared on read
// - overflow when byte arrives with buffer full
// - buffer write while busy: collision flag, kept
// - acknowledge pulls clock low, drives ack value
// - ack: low period, release, high period, idle
// - stop: data low, release clock, release data
// - stop seen flag, event one period later
// - keep receiving in sleep, wake on event
// - reset or disable aborts, clears bus flags
// - bus free rule, event on next stop
// - released one read low: collision, go idle
// - transmit collision: halt, clear full, release
// - sequence collision: abort, release, clear bits
// - after collision, stop on bus raises event
// - new write after collision restarts at bit zero
// - start with bus already low: collision, idle
// - clock low during first start count: collision
// - early data low resets count, second count
module i2c_master
  import i2c_master_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic        i_sleep,
  input  wire logic        i_scl_i,
  input  wire logic        i_sda_i,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  output logic             o_scl_o,
  output logic             o_scl_oe,
  output logic             o_sda_o,
  output logic             o_sda_oe,
  output logic             o_wake
);

  state_type r;
  state_type n;
  logic      tick;
  logic      acc;
  logic      wr_ctrl;
  logic      wr_stat;
  logic      wr_data;
  logic      rd_data;
  logic      start_det;
  logic      stop_det;
  logic      idle_now;
  logic      rx_done;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n         = r;
    rx_done   = 1'b0;
    tick      = (r.cnt == 7'h00);
    acc       = i_psel && i_penable && r.pready;
    wr_ctrl   = acc && i_pwrite && (i_paddr == ctrl_off);
    wr_stat   = acc && i_pwrite && (i_paddr == status_off);
    wr_data   = acc && i_pwrite && (i_paddr == data_off);
    rd_data   = acc && !i_pwrite && (i_paddr == data_off);
    start_det = r.scl_s && r.scl_p && r.sda_p && !r.sda_s;
    stop_det  = r.scl_s && r.scl_p && !r.sda_p && r.sda_s;

    // pins pass two flops before any logic reads them
    n.scl_m = i_scl_i;
    n.scl_s = r.scl_m;
    n.scl_p = r.scl_s;
    n.sda_m = i_sda_i;
    n.sda_s = r.sda_m;
    n.sda_p = r.sda_s;

    // clears go first so that a hardware set in the same cycle wins
    if (wr_stat) begin
      n.ovf  = r.ovf && !i_pwdata[st_ovf];
      n.write_collision_flag = r.write_collision_flag && !i_pwdata[st_write_collision_flag];
      n.bcol = r.bcol && !i_pwdata[st_bcol];
      n.evt  = r.evt && !i_pwdata[st_evt];
    end
    if (rd_data) begin
      n.bf = 1'b0;
    end

    n.cnt = tick ? r.rate : r.cnt - 7'h01;

    case (r.phase)
      ph_idle: begin
        n.cnt  = r.rate;
        n.step = 3'h0;
        n.bitn = 4'h0;
        if (r.start_go) begin
          if (!r.sda_s || !r.scl_s) begin
            n.bcol     = 1'b1;
            n.start_go = 1'b0;
            n.lost     = 1'b1;
          end else begin
            n.phase = ph_start;
          end
        end else if (r.stop_go) begin
          n.phase  = ph_stop;
          n.sda_oe = 1'b1;
        end else if (r.rcv_en) begin
          n.phase  = ph_rx;
          n.sda_oe = 1'b0;
          n.scl_oe = 1'b1;
        end else if (r.ack_go) begin
          n.phase  = ph_ack;
          n.scl_oe = 1'b1;
          n.sda_oe = !r.ack_value;
        end
      end
      ph_start: begin
        if (r.step == 3'h0) begin
          if (!r.scl_s && r.sda_s) begin
            n.phase    = ph_idle;
            n.bcol     = 1'b1;
            n.lost     = 1'b1;
            n.start_go = 1'b0;
            n.sda_oe   = 1'b0;
          end else if (!r.sda_s || tick) begin
            n.sda_oe = 1'b1;
            n.cnt    = r.rate;
            n.step   = 3'h1;
          end
        end else if (tick) begin
          n.scl_oe   = 1'b1;
          n.start_go = 1'b0;
          n.evt      = 1'b1;
          n.phase    = ph_idle;
        end
      end
      ph_tx: begin
        case (r.step)
          3'h0: begin
            if (tick) begin
              n.scl_oe = 1'b0;
              n.step   = 3'h1;
            end
          end
          3'h1: begin
            n.cnt = r.rate;
            if (r.scl_s) begin
              n.step = 3'h2;
            end
          end
          default: begin
            if (!r.sda_oe && !r.sda_s && r.bitn != ack_bit) begin
              n.phase  = ph_idle;
              n.bcol   = 1'b1;
              n.lost   = 1'b1;
              n.bf     = 1'b0;
              n.scl_oe = 1'b0;
              n.sda_oe = 1'b0;
            end else if (tick) begin
              n.scl_oe = 1'b1;
              n.step   = 3'h0;
              if (r.bitn == ack_bit) begin
                n.ack_stat = r.sda_s;
                n.evt      = 1'b1;
                n.phase    = ph_idle;
              end else begin
                n.shreg = {r.shreg[6:0], 1'b0};
                n.bitn  = r.bitn + 4'h1;
                if (r.bitn == last_bit) begin
                  n.bf     = 1'b0;
                  n.sda_oe = 1'b0;
                end else begin
                  n.sda_oe = !r.shreg[6];
                end
              end
            end
          end
        endcase
      end
      ph_rx: begin
        case (r.step)
          3'h0: begin
            n.sda_oe = 1'b0;
            if (tick) begin
              n.scl_oe = 1'b0;
              n.step   = 3'h1;
            end
          end
          3'h1: begin
            n.cnt = r.rate;
            if (r.scl_s) begin
              n.step = 3'h2;
            end
          end
          default: begin
            if (tick) begin
              n.shreg  = {r.shreg[6:0], r.sda_s};
              n.scl_oe = 1'b1;
              n.step   = 3'h0;
              n.bitn   = r.bitn + 4'h1;
              if (r.bitn == last_bit) begin
                rx_done  = 1'b1;
                n.buffer = {r.shreg[6:0], r.sda_s};
                n.ovf    = r.ovf || r.bf;
                n.bf     = 1'b1;
                n.evt    = 1'b1;
                n.rcv_en = 1'b0;
                n.phase  = ph_idle;
              end
            end
          end
        endcase
      end
      ph_ack: begin
        case (r.step)
          3'h0: begin
            if (tick) begin
              n.scl_oe = 1'b0;
              n.step   = 3'h1;
            end
          end
          3'h1: begin
            n.cnt = r.rate;
            if (r.scl_s) begin
              n.step = 3'h2;
            end
          end
          default: begin
            if (r.ack_value && !r.sda_s) begin
              n.phase  = ph_idle;
              n.bcol   = 1'b1;
              n.lost   = 1'b1;
              n.ack_go = 1'b0;
              n.scl_oe = 1'b0;
              n.sda_oe = 1'b0;
            end else if (tick) begin
              n.scl_oe = 1'b1;
              n.ack_go = 1'b0;
              n.phase  = ph_idle;
            end
          end
        endcase
      end
      ph_stop: begin
        case (r.step)
          3'h0: begin
            n.cnt = r.rate;
            if (!r.sda_s) begin
              n.step = 3'h1;
            end
          end
          3'h1: begin
            if (tick) begin
              n.scl_oe = 1'b0;
              n.step   = 3'h2;
            end
          end
          3'h2: begin
            n.cnt = r.rate;
            if (r.scl_s) begin
              n.step = 3'h3;
            end
          end
          3'h3: begin
            if (!r.scl_s) begin
              n.phase   = ph_idle;
              n.bcol    = 1'b1;
              n.lost    = 1'b1;
              n.stop_go = 1'b0;
              n.sda_oe  = 1'b0;
            end else if (tick) begin
              n.sda_oe = 1'b0;
              n.step   = 3'h4;
            end
          end
          3'h4: begin
            // count runs here so a data line held low really times out
            if (r.sda_s && r.scl_s) begin
              n.stop_seen = 1'b1;
              n.cnt       = r.rate;
              n.step      = 3'h5;
            end else if (tick) begin
              n.phase   = ph_idle;
              n.bcol    = 1'b1;
              n.lost    = 1'b1;
              n.stop_go = 1'b0;
            end
          end
          default: begin
            if (tick) begin
              n.stop_go = 1'b0;
              n.evt     = 1'b1;
              n.phase   = ph_idle;
            end
          end
        endcase
      end
      default: begin
        n.phase = ph_idle;
      end
    endcase

    // bus monitor keeps running after a lost arbitration
    if (start_det) begin
      n.start_seen = 1'b1;
      n.stop_seen  = 1'b0;
    end
    if (stop_det) begin
      n.stop_seen  = 1'b1;
      n.start_seen = 1'b0;
      if (r.lost || (r.start_seen && r.event_ie && r.phase != ph_stop)) begin
        n.evt  = 1'b1;
        n.lost = 1'b0;
      end
    end

    // command bits and data writes land only when the engine is and stays idle: no queueing
    idle_now = (r.phase == ph_idle) && (n.phase == ph_idle);
    if (wr_ctrl) begin
      n.enable    = i_pwdata[ctl_enable];
      n.ack_value = i_pwdata[ctl_ack_value];
      n.event_ie  = i_pwdata[ctl_event_ie];
      if (idle_now && r.enable) begin
        n.start_go = i_pwdata[ctl_start];
        n.stop_go  = i_pwdata[ctl_stop];
        n.rcv_en   = i_pwdata[ctl_rcv];
        n.ack_go   = i_pwdata[ctl_ack];
      end
    end
    if (acc && i_pwrite && (i_paddr == rate_off)) begin
      n.rate = i_pwdata[6:0];
    end
    if (wr_data) begin
      if (!idle_now || !r.enable) begin
        n.write_collision_flag = 1'b1;
      end else begin
        n.buffer = i_pwdata[7:0];
        n.shreg  = i_pwdata[7:0];
        n.bf     = 1'b1;
        n.lost   = 1'b0;
        n.phase  = ph_tx;
        n.step   = 3'h0;
        n.bitn   = 4'h0;
        n.cnt    = r.rate;
        n.scl_oe = 1'b1;
        n.sda_oe = !i_pwdata[7];
      end
    end

    if (!n.enable) begin
      n.phase      = ph_idle;
      n.scl_oe     = 1'b0;
      n.sda_oe     = 1'b0;
      n.start_go   = 1'b0;
      n.stop_go    = 1'b0;
      n.rcv_en     = 1'b0;
      n.ack_go     = 1'b0;
      n.stop_seen  = 1'b0;
      n.start_seen = 1'b0;
    end

    // apb: one wait state, read data latched with pready
    n.pready  = i_psel && i_penable && !r.pready;
    n.pslverr = 1'b0;
    n.prdata  = 32'h0000_0000;
    if (i_psel && i_penable && !r.pready) begin
      case (i_paddr)
        ctrl_off:   n.prdata = {25'h0, r.event_ie, r.ack_value, r.ack_go, r.rcv_en, r.stop_go, r.start_go, r.enable};
        status_off: n.prdata = {23'h0, r.stop_seen || (!r.start_seen && !r.stop_seen), r.ack_stat, r.start_seen,
                                r.stop_seen, r.evt, r.bcol, r.write_collision_flag, r.ovf, r.bf};
        data_off:   n.prdata = {24'h0, r.buffer};
        rate_off:   n.prdata = {25'h0, r.rate};
        default:    n.pslverr = 1'b1;
      endcase
    end

    n.wake = n.evt && n.event_ie && i_sleep;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      r        <= '0;
      r.phase  <= ph_idle;
      r.rate   <= rate_reset;
      r.cnt    <= rate_reset;
      r.scl_m  <= 1'b1;
      r.scl_s  <= 1'b1;
      r.scl_p  <= 1'b1;
      r.sda_m  <= 1'b1;
      r.sda_s  <= 1'b1;
      r.sda_p  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign o_pready  = r.pready;
  assign o_pslverr = r.pslverr;
  assign o_prdata  = r.prdata;
  assign o_scl_o   = 1'b0;
  assign o_sda_o   = 1'b0;
  assign o_scl_oe  = r.scl_oe;
  assign o_sda_oe  = r.sda_oe;
  assign o_wake    = r.wake;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  rx_ignored_a: assert property (wr_ctrl && i_pwdata[ctl_rcv] && r.phase != ph_idle && r.phase != ph_rx
                                 |=> r.phase != ph_rx) else $error("receive request taken while busy");
  rx_store_a: assert property (rx_done && n.enable |=> r.bf && r.evt && !r.rcv_en && r.scl_oe
                               && r.phase == ph_idle) else $error("byte store incomplete");
  bf_read_a: assert property (rd_data && !rx_done && !wr_data |=> !r.bf) else $error("buffer full not cleared");
  ovf_set_a: assert property (rx_done && r.bf |=> r.ovf) else $error("overflow missed");
  write_collision_flag_hold_a: assert property (wr_data && !rx_done && r.phase != ph_idle |=> r.write_collision_flag && $stable(r.buffer))
    else $error("busy write changed buffer");
  ack_drive_a: assert property (r.phase == ph_idle && r.ack_go && !r.start_go && !r.stop_go && !r.rcv_en
                                && n.enable |=> r.scl_oe && (r.sda_oe == !r.ack_value)) else $error("ack drive wrong");
  tx_coll_a: assert property (r.phase == ph_tx && r.step == 3'h2 && r.bitn != ack_bit && !r.sda_oe
                              && !r.sda_s && !wr_data |=> r.phase == ph_idle && r.bcol && !r.bf && !r.scl_oe)
    else $error("arbitration loss not handled");
  dis_clear_a: assert property (!r.enable |-> r.phase == ph_idle && !r.stop_seen && !r.start_seen && !r.scl_oe)
    else $error("disabled port not idle");
  start_low_a: assert property (r.phase == ph_idle && r.start_go && !r.sda_s |=> r.bcol ##1 r.phase == ph_idle)
    else $error("start on low bus not refused");

endmodule

`default_nettype wire

/* File: logic/i2c_master_pkg.sv */
/*
  constants, register map and state layout of the two-wire bus master engine.
  assumes a 20 mhz system clock and a 32-bit apb slave port in front of it.
*/
package i2c_master_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ctrl_off   = 8'h00;
  localparam logic [7:0] status_off = 8'h04;
  localparam logic [7:0] data_off   = 8'h08;
  localparam logic [7:0] rate_off   = 8'h0c;

  // control bits
  localparam int ctl_enable    = 0;
  localparam int ctl_start     = 1;
  localparam int ctl_stop      = 2;
  localparam int ctl_rcv       = 3;
  localparam int ctl_ack       = 4;
  localparam int ctl_ack_value = 5;
  localparam int ctl_event_ie  = 6;

  // status bits, 1 to 4 are write-one-to-clear
  localparam int st_bf         = 0;
  localparam int st_ovf        = 1;
  localparam int st_write_collision_flag       = 2;
  localparam int st_bcol       = 3;
  localparam int st_evt        = 4;
  localparam int st_stop_seen  = 5;
  localparam int st_start_seen = 6;
  localparam int st_ack_stat   = 7;
  localparam int st_bus_free   = 8;

  localparam logic [6:0] rate_reset = 7'h00;
  localparam logic [3:0] last_bit   = 4'h7;
  localparam logic [3:0] ack_bit    = 4'h8;

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {ph_idle, ph_start, ph_tx, ph_rx, ph_ack, ph_stop} phase_type;

  typedef struct packed {
    phase_type   phase;
    logic [2:0]  step;
    logic [6:0]  cnt;
    logic [6:0]  rate;
    logic [3:0]  bitn;
    logic [7:0]  shreg;
    logic [7:0]  buffer;
    logic        enable;
    logic        start_go;
    logic        stop_go;
    logic        rcv_en;
    logic        ack_go;
    logic        ack_value;
    logic        event_ie;
    logic        bf;
    logic        ovf;
    logic        write_collision_flag;
    logic        bcol;
    logic        evt;
    logic        stop_seen;
    logic        start_seen;
    logic        ack_stat;
    logic        lost;
    logic        scl_oe;
    logic        sda_oe;
    logic        scl_m;
    logic        scl_s;
    logic        scl_p;
    logic        sda_m;
    logic        sda_s;
    logic        sda_p;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        wake;
  } state_type;

endpackage

/* File: test/i2c_bus_model.sv */
/*
  far side of the two-wire bus: pull-ups, one slave that takes or sends bytes.
  assumes the master's enables pull low; the bench may pull sda for collisions.
*/
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
  input  wire logic       i_clk,
  input  wire logic       i_scl_oe,
  input  wire logic       i_sda_oe,
  input  wire logic       i_pull_sda,
  input  wire logic       i_read_mode,
  input  wire logic       i_ack_en,
  input  wire logic       i_stretch,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_scl,
  output logic            o_sda,
  output logic [7:0]      o_rx_byte
);
  logic       scl_q    = 1'b1;
  logic       sda_q    = 1'b1;
  logic       active_q = 1'b0;
  logic [3:0] bitc_q   = 4'hf;
  logic [4:0] hold_q   = 5'h00;
  logic       slave_low;
  logic [3:0] nb;

  // ************************************************************
  // wired-and with pull-ups
  // ************************************************************
  // combinational drive so a mode change by the bench releases at once
  assign slave_low = active_q && (i_read_mode ? (bitc_q < 4'h8 && !i_tx_byte[3'h7 - bitc_q[2:0]])
                                              : (bitc_q == 4'h8 && i_ack_en));
  assign o_scl = !(i_scl_oe || hold_q != 5'h00);
  assign o_sda = !(i_sda_oe || slave_low || i_pull_sda);
  assign nb    = (bitc_q >= 4'h8) ? 4'h0 : bitc_q + 4'h1;

  // ************************************************************
  // slave
  // ************************************************************
  always @(posedge i_clk) begin
    scl_q <= o_scl;
    sda_q <= o_sda;
    if (hold_q != 5'h00) begin
      hold_q <= hold_q - 5'h01;
    end
    if (scl_q && o_scl && sda_q && !o_sda) begin
      active_q <= 1'b1;
      bitc_q   <= 4'hf;
    end else if (scl_q && o_scl && !sda_q && o_sda) begin
      active_q <= 1'b0;
    end else if (active_q && !scl_q && o_scl && bitc_q < 4'h8) begin
      o_rx_byte <= {o_rx_byte[6:0], o_sda};
    end else if (active_q && scl_q && !o_scl) begin
      bitc_q <= nb;
      // slow answer: stretch the low phase
      if (i_stretch) begin
        hold_q <= 5'h0c;
      end
    end
  end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
/*
  self-checking bench of the bus master engine: apb driver, read scoreboard.
  assumes the bus model on the far side and a 20 mhz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import i2c_master_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pull = 1'b0, rmode = 1'b0, stretch = 1'b0;
  logic [7:0]  txb = 8'h00;
  logic        pready, pslverr, scl_oe, sda_oe, wake, scl, sda;
  logic [31:0] prdata, rv;
  logic [7:0]  rxb, b;
  logic [32:0] q_exp[$], q_msk[$], e, m;
  int          err_total = 0, compares = 0, i;

  initial begin
    forever #25 i_clk = ~i_clk;
  end

  i2c_master DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_sleep(sleep), .i_scl_i(scl), .i_sda_i(sda), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .o_scl_o(), .o_scl_oe(scl_oe), .o_sda_o(), .o_sda_oe(sda_oe),
    .o_wake(wake));
  i2c_bus_model bus (.i_clk(i_clk), .i_scl_oe(scl_oe), .i_sda_oe(sda_oe), .i_pull_sda(pull),
    .i_read_mode(rmode), .i_ack_en(1'b1), .i_stretch(stretch), .i_tx_byte(txb), .o_scl(scl), .o_sda(sda),
    .o_rx_byte(rxb));

  // ************************************************************
  // checks and drivers
  // ************************************************************
  task finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task timeout;
    err_total++;
    finish_test;
  endtask
  task check_word(input logic [32:0] x, input logic [32:0] a);
    compares++;
    if (a !== x) begin
      err_total++;
      $display("FAIL t=%0t exp=%h got=%h", $time, x, a);
    end
  endtask
  task check_bit(input logic x, input logic a);
    check_word({32'h0, x}, {32'h0, a});
  endtask
  // master holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) timeout;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rv);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] x, input logic [32:0] k);
    q_exp.push_back(x);
    q_msk.push_back(k);
    apb(1'b0, a, 32'h0, rv);
  endtask
  task poll(input logic [7:0] a, input int n, input logic v);
    int k;
    for (k = 0; k < 400; k++) begin
      q_exp.push_back(33'h0);
      q_msk.push_back(33'h0);
      apb(1'b0, a, 32'h0, rv);
      if (rv[n] === v) break;
    end
    if (k == 400) timeout;
  endtask
  // a finished start raises the event flag: clear it so later polls wait for their own event
  task start_bus;
    wr(ctrl_off, 32'h3);
    poll(ctrl_off, ctl_start, 1'b0);
    wr(status_off, 32'h10);
  endtask
  task ack(input logic v);
    wr(ctrl_off, 32'h11 | (32'(v) << 5));
    for (i = 0; i < 400 && scl_oe !== 1'b0; i++) @(posedge i_clk);
    if (i == 400) err_total++;
    check_bit(v, sda);
    poll(ctrl_off, ctl_ack, 1'b0);
    check_bit(1'b1, scl_oe);
  endtask
  task rx_byte(input logic [7:0] v);
    txb <= v;
    wr(ctrl_off, 32'h9);
    poll(status_off, st_evt, 1'b1);
    wr(status_off, 32'h10);
  endtask

  // scoreboard: oldest read note against each completed read
  always @(posedge i_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && q_exp.size() > 0) begin
      e = q_exp.pop_front();
      m = q_msk.pop_front();
      if (m != 33'h0) check_word(e & m, {pslverr, prdata} & m);
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    void'($urandom(32'h0c9a9304));
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(status_off, 33'h100, 33'h1ff);
    rd(ctrl_off, 33'h0, 33'h7f);
    rd(8'h10, 33'h100000000, 33'h1ffffffff);
    wr(rate_off, 32'h3);
    wr(ctrl_off, 32'h1);
    start_bus;
    rd(status_off, 33'h040, 33'h160);
    b = 8'($urandom);
    wr(data_off, {24'h0, b});
    wr(data_off, {24'h0, ~b});
    poll(status_off, st_evt, 1'b1);
    check_word({25'h0, b}, {25'h0, rxb});
    rd(status_off, 33'h014, 33'h095);
    wr(status_off, 32'h1e);
    b = 8'($urandom);
    txb <= b;
    rmode <= 1'b1;
    stretch <= 1'b1;
    wr(ctrl_off, 32'h9);
    wr(data_off, 32'h5a);
    poll(status_off, st_evt, 1'b1);
    rd(status_off, 33'h015, 33'h017);
    rd(ctrl_off, 33'h1, 33'h1f);
    check_bit(1'b1, scl_oe);
    rd(data_off, {25'h0, b}, 33'hff);
    rd(status_off, 33'h0, 33'h1);
    wr(status_off, 32'h1e);
    ack(1'b0);
    rx_byte(8'($urandom));
    ack(1'b0);
    rx_byte(8'($urandom));
    rd(status_off, 33'h3, 33'h3);
    ack(1'b1);
    rmode <= 1'b0;
    stretch <= 1'b0;
    wr(ctrl_off, 32'h5);
    wr(ctrl_off, 32'hd);
    poll(ctrl_off, ctl_stop, 1'b0);
    rd(status_off, 33'h130, 33'h130);
    rd(ctrl_off, 33'h1, 33'h0f);
    check_bit(1'b0, sda_oe);
    check_bit(1'b0, scl_oe);
    wr(status_off, 32'h1e);
    start_bus;
    wr(data_off, 32'hff);
    pull <= 1'b1;
    poll(status_off, st_bcol, 1'b1);
    rd(status_off, 33'h08, 33'h09);
    check_bit(1'b0, sda_oe);
    check_bit(1'b0, scl_oe);
    wr(status_off, 32'h1e);
    pull <= 1'b0;
    poll(status_off, st_evt, 1'b1);
    start_bus;
    b = 8'($urandom);
    wr(data_off, {24'h0, b});
    poll(status_off, st_evt, 1'b1);
    check_word({25'h0, b}, {25'h0, rxb});
    wr(ctrl_off, 32'h5);
    poll(ctrl_off, ctl_stop, 1'b0);
    wr(status_off, 32'h1e);
    pull <= 1'b1;
    start_bus;
    rd(status_off, 33'h08, 33'h08);
    check_bit(1'b0, sda_oe);
    wr(status_off, 32'h1e);
    wr(ctrl_off, 32'h41);
    sleep <= 1'b1;
    pull <= 1'b0;
    for (i = 0; i < 400 && wake !== 1'b1; i++) @(posedge i_clk);
    if (i == 400) err_total++;
    check_bit(1'b1, wake);
    sleep <= 1'b0;
    wr(ctrl_off, 32'h1);
    start_bus;
    wr(data_off, 32'h0);
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    check_bit(1'b0, sda_oe);
    check_bit(1'b0, scl_oe);
    rd(status_off, 33'h100, 33'h160);
    rd(ctrl_off, 33'h0, 33'h7f);
    finish_test;
  end
endmodule
`default_nettype wire
